// >>> design/scr_pkg.sv
// Constants and types shared by the configuration register group and its decoder.
package scr_pkg;
	localparam logic [7:0] SCR_IDX_FDD_SETUP   = 8'h05;
	localparam logic [7:0] SCR_IDX_DRIVE_TYPES = 8'h06;
	localparam logic [7:0] SCR_IDX_POWER_BOOT  = 8'h07;
	localparam logic [7:0] SCR_IDX_AUX_LOW     = 8'h08;
	localparam logic [7:0] SCR_IDX_AUX_HIGH    = 8'h09;
	localparam logic [7:0] SCR_IDX_ECP_THR     = 8'h0A;
	localparam logic [7:0] SCR_IDX_RATE_SEL    = 8'h0B;

	localparam logic [7:0] SCR_RST_ZERO        = 8'h00;
	localparam logic [7:0] SCR_RST_DRIVE_TYPES = 8'hFF;

	localparam logic [7:0] SCR_MASK_FDD_SETUP  = 8'h7C;
	localparam logic [7:0] SCR_MASK_POWER_BOOT = 8'hF3;
	localparam logic [7:0] SCR_MASK_ECP_THR    = 8'h0F;
	localparam logic [7:0] SCR_MASK_FULL       = 8'hFF;

	localparam int SCR_SETUP_DMA_BIT   = 2;
	localparam int SCR_SETUP_DEN_LSB   = 3;
	localparam int SCR_SETUP_SWAP_BIT  = 5;
	localparam int SCR_SETUP_EXT4_BIT  = 6;
	localparam int SCR_BOOT_LSB        = 0;
	localparam int SCR_PD_LSB          = 4;
	localparam int SCR_AUX_LOW_LSB     = 4;
	localparam int SCR_AUX_HIGH_LSB    = 0;
	localparam int SCR_AUX_MODE_LSB    = 6;
	localparam int SCR_THR_LSB         = 0;

	localparam logic [1:0] SCR_DEN_NORMAL   = 2'h0;
	localparam logic [1:0] SCR_DEN_RESERVED = 2'h1;
	localparam logic [1:0] SCR_DEN_HIGH     = 2'h2;
	localparam logic [1:0] SCR_DEN_LOW      = 2'h3;

	localparam logic [1:0] SCR_PEXT_SPP     = 2'h0;
	localparam logic [1:0] SCR_PEXT_EPP     = 2'h1;
	localparam logic [1:0] SCR_PEXT_ECP     = 2'h2;
	localparam logic [1:0] SCR_PEXT_ECP_EPP = 2'h3;
	localparam logic [2:0] SCR_ECR_SPP      = 3'h0;
	localparam logic [2:0] SCR_ECR_EPP      = 3'h4;

	localparam logic [3:0] SCR_PRESCALE_STD  = 4'hD;
	localparam logic [3:0] SCR_PRESCALE_MIDI = 4'hC;

	typedef enum logic [1:0] {
		SCR_AUX_OFF     = 2'h0,
		SCR_AUX_ONE     = 2'h1,
		SCR_AUX_EIGHT   = 2'h2,
		SCR_AUX_SIXTEEN = 2'h3
	} scr_aux_mode_t;

	typedef enum logic [2:0] {
		SCR_PAR_SPP = 3'h1,
		SCR_PAR_EPP = 3'h2,
		SCR_PAR_ECP = 3'h4
	} scr_par_op_t;
endpackage

// >>> design/scr_aux_if.sv
// Carrier between the register group and the auxiliary address decoder.
`timescale 1ns/10ps
interface scr_aux_if;
	import scr_pkg::*;
	logic [10:4]   base_addr;
	scr_aux_mode_t mode;
	logic [10:0]   addr;
	logic          cs_n;
	logic          hit;
	modport regs (output base_addr, output mode, output addr, output cs_n, input hit);
	modport dec  (input base_addr, input mode, input addr, input cs_n, output hit);
endinterface

// >>> design/scr_aux_decoder.sv
// Auxiliary general-purpose address decoder with registered match output.
`timescale 1ns/10ps
module scr_aux_decoder (
	input wire logic core_clk,
	input wire logic rst_n,
	scr_aux_if.dec   aux
);
	import scr_pkg::*;

	logic upper_match;
	logic low_match;
	logic hit_reg;
	logic hit_next;

	assign upper_match = (aux.addr[10:4] == aux.base_addr);

	always_comb begin
		case (aux.mode)
			SCR_AUX_OFF:     low_match = 1'b0;
			SCR_AUX_ONE:     low_match = (aux.addr[3:0] == 4'h0);
			SCR_AUX_EIGHT:   low_match = ~aux.addr[3];
			SCR_AUX_SIXTEEN: low_match = 1'b1;
			default:         low_match = 1'b0;
		endcase
	end

	assign hit_next = ~aux.cs_n & upper_match & low_match;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_reg <= 1'b0;
		end else begin
			hit_reg <= hit_next;
		end
	end

	assign aux.hit = hit_reg;
endmodule // scr_aux_decoder

// >>> design/scr_config_regs.sv
// Configuration registers 05h to 0Bh, the floppy and decoder logic they steer, and the input-driven parallel and prescale mode logic.
`timescale 1ns/10ps
module scr_config_regs (
	input  wire logic                 CORE_CLK,
	input  wire logic                 RST_N,
	input  wire logic                 CFG_MODE,
	input  wire logic                 INDEX_WR,
	input  wire logic                 DATA_WR,
	input  wire logic                 DATA_RD,
	input  wire logic [7:0]           WDATA,
	output logic      [7:0]           RDATA,
	input  wire logic [10:0]          ADDR,
	input  wire logic                 CHIP_SELECT_LOW_N,
	output logic                      AUX_ADDRESS_DECODER_OUTPUT,
	input  wire logic                 FDC_DMA_REQ,
	input  wire logic                 FDC_INT_REQ,
	input  wire logic                 FDC_BYTE_DONE,
	input  wire logic                 FDC_FIFO_EN,
	output logic                      FLOPPY_DMA_REQUEST,
	output logic                      FLOPPY_INTERRUPT_REQUEST,
	input  wire logic                 DENSITY_IN,
	output logic                      DENSITY_SELECT,
	input  wire logic [1:0]           FDC_DRIVE_NUM,
	input  wire logic                 FDC_DRIVE_ACTIVE,
	input  wire logic [3:0]           FDC_MOTOR_ON,
	output logic      [1:0]           DRIVE_SELECT,
	output logic      [1:0]           MOTOR_SELECT,
	output logic                      DRIVE_DECODE_ENABLE,
	output logic                      FOUR_DRIVE_EXTERNAL_DECODE,
	output logic      [7:0]           DRIVE_TYPES,
	output logic      [1:0]           BOOT_DRIVE,
	output logic      [3:0]           AUTO_POWERDOWN_EN,
	output logic      [3:0]           ECP_FIFO_THRESHOLD,
	output logic      [7:0]           RATE_TABLE_SELECT,
	input  wire logic [1:0]           PARALLEL_EXT_MODE,
	input  wire logic [2:0]           ECR_MODE,
	output scr_pkg::scr_par_op_t      PARALLEL_OPERATION,
	input  wire logic [1:0]           MUSIC_CLOCK_SELECT,
	output logic      [3:0]           UART1_PRESCALE,
	output logic      [3:0]           UART2_PRESCALE
);
	import scr_pkg::*;

	scr_aux_if aux ();

	logic [7:0]  config_index_register_reg;
	logic [7:0]  fdd_setup_reg;
	logic [7:0]  drive_types_reg;
	logic [7:0]  power_boot_reg;
	logic [7:0]  aux_low_reg;
	logic [7:0]  aux_high_reg;
	logic [7:0]  ecp_thr_reg;
	logic [7:0]  rate_sel_reg;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic        data_wr_ok;
	logic [10:0] addr_meta_reg;
	logic [10:0] addr_sync_reg;
	logic        cs_meta_reg;
	logic        cs_sync_reg;
	logic        non_burst;
	logic [1:0]  den_code;
	logic        swap_en;
	logic        ext_decode;
	logic [1:0]  swapped_num;
	logic [3:0]  swapped_motor;
	logic        drq_reg;
	logic        irq_reg;
	logic        density_reg;
	logic [1:0]  drive_sel_reg;
	logic [1:0]  drive_sel_next;
	logic [1:0]  motor_sel_reg;
	logic [1:0]  motor_sel_next;
	logic        drive_en_reg;
	scr_par_op_t par_op_reg;
	scr_par_op_t par_op_next;
	logic [3:0]  uart1_pre_reg;
	logic [3:0]  uart2_pre_reg;

	// Data strobes outside configuration mode never touch the registers.
	assign data_wr_ok = CFG_MODE & DATA_WR;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			config_index_register_reg <= SCR_RST_ZERO;
		end else if (CFG_MODE && INDEX_WR) begin
			config_index_register_reg <= WDATA;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fdd_setup_reg   <= SCR_RST_ZERO;
			drive_types_reg <= SCR_RST_DRIVE_TYPES;
			power_boot_reg  <= SCR_RST_ZERO;
			aux_low_reg     <= SCR_RST_ZERO;
			aux_high_reg    <= SCR_RST_ZERO;
			ecp_thr_reg     <= SCR_RST_ZERO;
			rate_sel_reg    <= SCR_RST_ZERO;
		end else if (data_wr_ok) begin
			case (config_index_register_reg)
				SCR_IDX_FDD_SETUP:   fdd_setup_reg   <= WDATA & SCR_MASK_FDD_SETUP;
				SCR_IDX_DRIVE_TYPES: drive_types_reg <= WDATA & SCR_MASK_FULL;
				SCR_IDX_POWER_BOOT:  power_boot_reg  <= WDATA & SCR_MASK_POWER_BOOT;
				SCR_IDX_AUX_LOW:     aux_low_reg     <= WDATA & SCR_MASK_FULL;
				SCR_IDX_AUX_HIGH:    aux_high_reg    <= WDATA & SCR_MASK_FULL;
				SCR_IDX_ECP_THR:     ecp_thr_reg     <= WDATA & SCR_MASK_ECP_THR;
				SCR_IDX_RATE_SEL:    rate_sel_reg    <= WDATA & SCR_MASK_FULL;
				default: begin
				end
			endcase
		end
	end

	// Masked storage keeps reserved bits zero, so reads need no extra gating.
	always_comb begin
		case (config_index_register_reg)
			SCR_IDX_FDD_SETUP:   rdata_next = fdd_setup_reg;
			SCR_IDX_DRIVE_TYPES: rdata_next = drive_types_reg;
			SCR_IDX_POWER_BOOT:  rdata_next = power_boot_reg;
			SCR_IDX_AUX_LOW:     rdata_next = aux_low_reg;
			SCR_IDX_AUX_HIGH:    rdata_next = aux_high_reg;
			SCR_IDX_ECP_THR:     rdata_next = ecp_thr_reg;
			SCR_IDX_RATE_SEL:    rdata_next = rate_sel_reg;
			default:             rdata_next = SCR_RST_ZERO;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_reg <= SCR_RST_ZERO;
		end else if (DATA_RD) begin
			rdata_reg <= CFG_MODE ? rdata_next : SCR_RST_ZERO;
		end
	end

	assign RDATA = rdata_reg;

	// Address and chip select are pins; the first stage feeds only the second.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			addr_meta_reg <= 11'h000;
			addr_sync_reg <= 11'h000;
			cs_meta_reg   <= 1'b1;
			cs_sync_reg   <= 1'b1;
		end else begin
			addr_meta_reg <= ADDR;
			addr_sync_reg <= addr_meta_reg;
			cs_meta_reg   <= CHIP_SELECT_LOW_N;
			cs_sync_reg   <= cs_meta_reg;
		end
	end

	assign aux.base_addr = {aux_high_reg[SCR_AUX_HIGH_LSB+2:SCR_AUX_HIGH_LSB],
		aux_low_reg[SCR_AUX_LOW_LSB+3:SCR_AUX_LOW_LSB]};
	assign aux.mode      = scr_aux_mode_t'(aux_high_reg[SCR_AUX_MODE_LSB+1:SCR_AUX_MODE_LSB]);
	assign aux.addr      = addr_sync_reg;
	assign aux.cs_n      = cs_sync_reg;

	scr_aux_decoder u_aux_decoder (
		.core_clk (CORE_CLK),
		.rst_n    (RST_N),
		.aux      (aux.dec)
	);

	assign AUX_ADDRESS_DECODER_OUTPUT = aux.hit;

	assign non_burst  = fdd_setup_reg[SCR_SETUP_DMA_BIT];
	assign den_code   = fdd_setup_reg[SCR_SETUP_DEN_LSB+1:SCR_SETUP_DEN_LSB];
	assign swap_en    = fdd_setup_reg[SCR_SETUP_SWAP_BIT];
	assign ext_decode = fdd_setup_reg[SCR_SETUP_EXT4_BIT];

	// A one-cycle gap after each byte turns a held request into a per-byte strobe.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			drq_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			drq_reg <= FDC_DMA_REQ & ~(non_burst & FDC_FIFO_EN & FDC_BYTE_DONE);
			irq_reg <= FDC_INT_REQ & ~(non_burst & FDC_FIFO_EN & FDC_BYTE_DONE);
		end
	end

	assign FLOPPY_DMA_REQUEST       = drq_reg;
	assign FLOPPY_INTERRUPT_REQUEST = irq_reg;

	// The reserved density code behaves as normal rather than an undefined level.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			density_reg <= 1'b0;
		end else begin
			case (den_code)
				SCR_DEN_HIGH: density_reg <= 1'b1;
				SCR_DEN_LOW:  density_reg <= 1'b0;
				default:      density_reg <= DENSITY_IN;
			endcase
		end
	end

	assign DENSITY_SELECT = density_reg;

	assign swapped_num   = (swap_en && !FDC_DRIVE_NUM[1]) ?
		{FDC_DRIVE_NUM[1], ~FDC_DRIVE_NUM[0]} : FDC_DRIVE_NUM;
	assign swapped_motor = swap_en ?
		{FDC_MOTOR_ON[3:2], FDC_MOTOR_ON[0], FDC_MOTOR_ON[1]} : FDC_MOTOR_ON;

	// Internal decode reaches only drives 0 and 1; drives 2 and 3 need the external decoder.
	always_comb begin
		if (ext_decode) begin
			drive_sel_next = FDC_DRIVE_ACTIVE ? swapped_num : 2'h0;
			motor_sel_next = {1'b0, swapped_motor[swapped_num]};
		end else begin
			drive_sel_next = 2'h0;
			if (FDC_DRIVE_ACTIVE && !swapped_num[1]) begin
				drive_sel_next = swapped_num[0] ? 2'h2 : 2'h1;
			end
			motor_sel_next = swapped_motor[1:0];
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			drive_sel_reg <= 2'h0;
			motor_sel_reg <= 2'h0;
			drive_en_reg  <= 1'b0;
		end else begin
			drive_sel_reg <= drive_sel_next;
			motor_sel_reg <= motor_sel_next;
			drive_en_reg  <= FDC_DRIVE_ACTIVE;
		end
	end

	assign DRIVE_SELECT               = drive_sel_reg;
	assign MOTOR_SELECT               = motor_sel_reg;
	assign DRIVE_DECODE_ENABLE        = drive_en_reg;
	assign FOUR_DRIVE_EXTERNAL_DECODE = ext_decode;

	assign DRIVE_TYPES        = drive_types_reg;
	assign BOOT_DRIVE         = power_boot_reg[SCR_BOOT_LSB+1:SCR_BOOT_LSB];
	assign AUTO_POWERDOWN_EN  = power_boot_reg[SCR_PD_LSB+3:SCR_PD_LSB];
	assign ECP_FIFO_THRESHOLD = ecp_thr_reg[SCR_THR_LSB+3:SCR_THR_LSB];
	assign RATE_TABLE_SELECT  = rate_sel_reg;

	always_comb begin
		case (PARALLEL_EXT_MODE)
			SCR_PEXT_SPP: par_op_next = SCR_PAR_SPP;
			SCR_PEXT_EPP: par_op_next = SCR_PAR_EPP;
			SCR_PEXT_ECP: par_op_next = (ECR_MODE == SCR_ECR_SPP) ? SCR_PAR_SPP : SCR_PAR_ECP;
			SCR_PEXT_ECP_EPP: begin
				if (ECR_MODE == SCR_ECR_EPP) begin
					par_op_next = SCR_PAR_EPP;
				end else if (ECR_MODE == SCR_ECR_SPP) begin
					par_op_next = SCR_PAR_SPP;
				end else begin
					par_op_next = SCR_PAR_ECP;
				end
			end
			default: par_op_next = SCR_PAR_SPP;
		endcase
	end

	// Divide-by-12 from a 24 MHz reference then by 16 gives the 125 kHz music rate.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			par_op_reg    <= SCR_PAR_SPP;
			uart1_pre_reg <= SCR_PRESCALE_STD;
			uart2_pre_reg <= SCR_PRESCALE_STD;
		end else begin
			par_op_reg    <= par_op_next;
			uart1_pre_reg <= MUSIC_CLOCK_SELECT[0] ? SCR_PRESCALE_MIDI : SCR_PRESCALE_STD;
			uart2_pre_reg <= MUSIC_CLOCK_SELECT[1] ? SCR_PRESCALE_MIDI : SCR_PRESCALE_STD;
		end
	end

	assign PARALLEL_OPERATION = par_op_reg;
	assign UART1_PRESCALE     = uart1_pre_reg;
	assign UART2_PRESCALE     = uart2_pre_reg;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	property p_reserved_zero;
		(CFG_MODE && DATA_RD && config_index_register_reg == SCR_IDX_FDD_SETUP)
			|=> (RDATA[1:0] == 2'h0 && RDATA[7] == 1'b0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("setup reserved bits read nonzero");

	property p_setup_write;
		(data_wr_ok && config_index_register_reg == SCR_IDX_FDD_SETUP)
			|=> (fdd_setup_reg == ($past(WDATA) & SCR_MASK_FDD_SETUP));
	endproperty
	a_setup_write: assert property (p_setup_write) else $error("setup write not stored");

	property p_no_write_outside;
		(!CFG_MODE && DATA_WR && !INDEX_WR) |=> $stable(fdd_setup_reg) && $stable(power_boot_reg);
	endproperty
	a_no_write_outside: assert property (p_no_write_outside) else $error("write outside config mode");

	property p_nonburst_gap;
		(non_burst && FDC_FIFO_EN && FDC_BYTE_DONE) |=> !FLOPPY_DMA_REQUEST && !FLOPPY_INTERRUPT_REQUEST;
	endproperty
	a_nonburst_gap: assert property (p_nonburst_gap) else $error("no per-byte strobe gap");

	property p_burst_pass;
		(!non_burst && FDC_DMA_REQ) |=> FLOPPY_DMA_REQUEST;
	endproperty
	a_burst_pass: assert property (p_burst_pass) else $error("burst request dropped");

	property p_density_force;
		(den_code == SCR_DEN_HIGH) ##1 (den_code == SCR_DEN_LOW) |=> !DENSITY_SELECT && $past(DENSITY_SELECT);
	endproperty
	a_density_force: assert property (p_density_force) else $error("density force wrong");

	property p_swap;
		(swap_en && !ext_decode && FDC_DRIVE_ACTIVE && FDC_DRIVE_NUM == 2'h0) |=> DRIVE_SELECT == 2'h2;
	endproperty
	a_swap: assert property (p_swap) else $error("drive swap wrong");

	property p_ext_decode;
		(ext_decode && !swap_en && FDC_DRIVE_ACTIVE) |=> DRIVE_SELECT == $past(FDC_DRIVE_NUM);
	endproperty
	a_ext_decode: assert property (p_ext_decode) else $error("encoded select wrong");

	property p_cs_gate;
		CHIP_SELECT_LOW_N [*4] |-> !AUX_ADDRESS_DECODER_OUTPUT;
	endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("decoder active without chip select");

	property p_thr_read;
		(CFG_MODE && DATA_RD && config_index_register_reg == SCR_IDX_ECP_THR) |=> RDATA[7:4] == 4'h0;
	endproperty
	a_thr_read: assert property (p_thr_read) else $error("threshold high nibble nonzero");

	property p_epp_entry;
		(PARALLEL_EXT_MODE == SCR_PEXT_ECP_EPP && ECR_MODE == SCR_ECR_EPP) |=> PARALLEL_OPERATION == SCR_PAR_EPP;
	endproperty
	a_epp_entry: assert property (p_epp_entry) else $error("EPP not entered");

	property p_prescale;
		MUSIC_CLOCK_SELECT[0] ##1 !MUSIC_CLOCK_SELECT[0] |=> UART1_PRESCALE == SCR_PRESCALE_STD
			&& $past(UART1_PRESCALE) == SCR_PRESCALE_MIDI;
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescale select wrong");

	c_setup_write: cover property (data_wr_ok && config_index_register_reg == SCR_IDX_FDD_SETUP);
	c_aux_hit:     cover property (AUX_ADDRESS_DECODER_OUTPUT);
	c_nonburst:    cover property (non_burst && FDC_FIFO_EN && FDC_BYTE_DONE && FDC_DMA_REQ);
	c_epp:         cover property (PARALLEL_OPERATION == SCR_PAR_EPP);
endmodule // scr_config_regs

// >>> tb/scr_host_model.sv
// Host model that drives the configuration index and data port.
`timescale 1ns/10ps
module scr_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic            cfg_mode,
	output logic            index_wr,
	output logic            data_wr,
	output logic            data_rd,
	output logic [7:0]      wdata
);
	initial begin
		{cfg_mode, index_wr, data_wr, data_rd} = 4'h0;
		wdata = 8'h00;
	end
	// The index always goes in one edge ahead of the data access.
	task automatic put_index(input logic cfg, input logic [7:0] idx);
		@(negedge clk);
		cfg_mode = cfg;
		index_wr = 1'b1;
		wdata    = idx;
	endtask
	task automatic wr(input logic cfg, input logic [7:0] idx, input logic [7:0] d);
		put_index(cfg, idx);
		@(negedge clk);
		index_wr = 1'b0;
		data_wr  = 1'b1;
		wdata    = d;
		@(negedge clk);
		data_wr  = 1'b0;
		cfg_mode = 1'b0;
	endtask
	task automatic rd(input logic cfg, input logic [7:0] idx, output logic [7:0] d);
		put_index(cfg, idx);
		@(negedge clk);
		index_wr = 1'b0;
		data_rd  = 1'b1;
		@(negedge clk);
		data_rd  = 1'b0;
		cfg_mode = 1'b0;
		d        = rdata;
	endtask
endmodule // scr_host_model

// >>> tb/tb_scr_config_regs.sv
// Self-checking bench for the configuration register group.
`timescale 1ns/10ps
module tb_scr_config_regs;
	import scr_pkg::*;
	logic        clk, rst_n, cfg, iwr, dwr, drd, cs_n, aux, dma_i, int_i, bdone, fifo;
	logic        dma_o, int_o, den_i, den_o, act, ext4, drv_en;
	logic [7:0]  wdata, rdata, rate, types, got;
	logic [10:0] addr;
	logic [1:0]  num, dsel, msel, boot, pext, music;
	logic [3:0]  mot, apd, thr, pre1, pre2;
	logic [2:0]  ecr;
	scr_par_op_t par;
	int          n_mismatch, checks_done;
	logic [7:0]  msk [7] = '{8'h7C, 8'hFF, 8'hF3, 8'hFF, 8'hFF, 8'h0F, 8'hFF};
	logic [7:0]  rstv [7] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  sw_cfg [5] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h60};
	logic [1:0]  sw_num [5] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h2};
	logic [3:0]  sw_mot [5] = '{4'h1, 4'h1, 4'h4, 4'h3, 4'h4};
	logic [3:0]  sw_exp [5] = '{4'h5, 4'hA, 4'h9, 4'h5, 4'h9};
	// Each entry packs extended mode, control mode and the expected one-hot operation.
	logic [7:0]  pv [8] = '{8'h01, 8'h21, 8'h42, 8'h81, 8'hA4, 8'hE2, 8'hC1, 8'hDC};

	scr_config_regs i_scr_config_regs (
		.CORE_CLK(clk), .RST_N(rst_n), .CFG_MODE(cfg), .INDEX_WR(iwr), .DATA_WR(dwr),
		.DATA_RD(drd), .WDATA(wdata), .RDATA(rdata), .ADDR(addr),
		.CHIP_SELECT_LOW_N(cs_n), .AUX_ADDRESS_DECODER_OUTPUT(aux),
		.FDC_DMA_REQ(dma_i), .FDC_INT_REQ(int_i), .FDC_BYTE_DONE(bdone),
		.FDC_FIFO_EN(fifo), .FLOPPY_DMA_REQUEST(dma_o), .FLOPPY_INTERRUPT_REQUEST(int_o),
		.DENSITY_IN(den_i), .DENSITY_SELECT(den_o), .FDC_DRIVE_NUM(num),
		.FDC_DRIVE_ACTIVE(act), .FDC_MOTOR_ON(mot), .DRIVE_SELECT(dsel),
		.MOTOR_SELECT(msel), .DRIVE_DECODE_ENABLE(drv_en), .FOUR_DRIVE_EXTERNAL_DECODE(ext4),
		.DRIVE_TYPES(types), .BOOT_DRIVE(boot), .AUTO_POWERDOWN_EN(apd),
		.ECP_FIFO_THRESHOLD(thr), .RATE_TABLE_SELECT(rate), .PARALLEL_EXT_MODE(pext),
		.ECR_MODE(ecr), .PARALLEL_OPERATION(par), .MUSIC_CLOCK_SELECT(music),
		.UART1_PRESCALE(pre1), .UART2_PRESCALE(pre2)
	);

	scr_host_model i_scr_host_model (
		.clk(clk), .rdata(rdata), .cfg_mode(cfg), .index_wr(iwr), .data_wr(dwr),
		.data_rd(drd), .wdata(wdata)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic complete_run();
		$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Nothing below waits on the design, so a plain cycle limit cuts off any hang.
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("unexpected at %0t: run limit reached", $time);
		complete_run();
	end

	initial begin
		logic [7:0] pat;
		logic       e;
		int         i, m, j, c;
		rst_n = 1'b0;
		{cs_n, dma_i, int_i, bdone, fifo, den_i, act} = 7'h40;
		addr  = 11'h000;
		num   = 2'h0;
		mot   = 4'h0;
		pext  = 2'h0;
		ecr   = 3'h0;
		music = 2'h0;
		cyc(6);
		rst_n = 1'b1;
		chk(types, 8'hFF, "drive types at reset");
		chk({apd, 2'h0, boot}, 8'h00, "powerdown and boot at reset");
		chk({pre1, pre2}, 8'hDD, "prescale at reset");
		for (i = 0; i < 7; i++) begin
			i_scr_host_model.rd(1'b1, 8'(5 + i), got);
			chk(got, rstv[i], "reset value");
		end
		for (j = 0; j < 2; j++) begin
			pat = (j == 0) ? 8'hFF : 8'hA5;
			for (i = 0; i < 7; i++) begin
				i_scr_host_model.wr(1'b1, 8'(5 + i), pat);
				i_scr_host_model.rd(1'b1, 8'(5 + i), got);
				chk(got, pat & msk[i], "read back");
			end
		end
		chk({apd, thr}, 8'hA5, "powerdown and threshold");
		chk({6'h00, boot}, 8'h01, "boot drive B");
		chk(rate, 8'hA5, "rate table");
		i_scr_host_model.wr(1'b1, 8'h0C, 8'hFF);
		i_scr_host_model.rd(1'b1, 8'h0C, got);
		chk(got, 8'h00, "unmapped index");
		i_scr_host_model.wr(1'b0, 8'h06, 8'h00);
		i_scr_host_model.rd(1'b1, 8'h06, got);
		chk(got, 8'hA5, "write outside config mode");
		i_scr_host_model.rd(1'b0, 8'h06, got);
		chk(got, 8'h00, "read outside config mode");
		for (c = 0; c < 4; c++) begin
			i_scr_host_model.wr(1'b1, 8'h05, 8'(c << 3));
			for (j = 0; j < 2; j++) begin
				den_i = j[0];
				cyc(2);
				e = (c == 2) ? 1'b1 : (c == 3) ? 1'b0 : j[0];
				chk({7'h00, den_o}, {7'h00, e}, "density select");
			end
		end
		i_scr_host_model.wr(1'b1, 8'h05, 8'h04);
		{dma_i, int_i, fifo} = 3'h7;
		cyc(2);
		chk({6'h00, dma_o, int_o}, 8'h03, "requests follow core");
		bdone = 1'b1;
		cyc(1);
		bdone = 1'b0;
		chk({6'h00, dma_o, int_o}, 8'h00, "non-burst byte strobe");
		cyc(2);
		chk({6'h00, dma_o, int_o}, 8'h03, "requests back after strobe");
		i_scr_host_model.wr(1'b1, 8'h05, 8'h00);
		bdone = 1'b1;
		cyc(2);
		bdone = 1'b0;
		chk({6'h00, dma_o, int_o}, 8'h03, "burst mode ignores strobe");
		act = 1'b1;
		for (i = 0; i < 5; i++) begin
			i_scr_host_model.wr(1'b1, 8'h05, sw_cfg[i]);
			num = sw_num[i];
			mot = sw_mot[i];
			cyc(2);
			chk({2'h0, drv_en, ext4, dsel, msel}, {2'h0, 1'b1, sw_cfg[i][6], sw_exp[i]}, "swap decode");
		end
		act = 1'b0;
		cyc(2);
		chk({5'h00, drv_en, dsel}, 8'h00, "drive idle");
		i_scr_host_model.wr(1'b1, 8'h08, 8'h30);
		for (m = 0; m < 4; m++) begin
			i_scr_host_model.wr(1'b1, 8'h09, {m[1:0], 6'h06});
			for (j = 0; j < 6; j++) begin
				cs_n = j[0];
				addr = {7'h63, (j < 2) ? 4'h0 : (j < 4) ? 4'h5 : 4'h9};
				cyc(4);
				e = !cs_n && ((m == 1 && addr[3:0] == 4'h0) || (m == 2 && !addr[3]) || m == 3);
				chk({7'h00, aux}, {7'h00, e}, "aux decode");
			end
		end
		cs_n = 1'b0;
		// Upper bits 011 are the reverse of the programmed 110, so a flipped order would hit.
		addr = 11'h330;
		cyc(4);
		chk({7'h00, aux}, 8'h00, "aux upper bits mismatch");
		for (i = 0; i < 8; i++) begin
			pext = pv[i][7:6];
			ecr  = pv[i][5:3];
			cyc(2);
			chk({5'h00, par}, {5'h00, pv[i][2:0]}, "par op");
		end
		music = 2'h1;
		cyc(2);
		chk({pre1, pre2}, 8'hCD, "first port music clock");
		music = 2'h2;
		cyc(2);
		chk({pre1, pre2}, 8'hDC, "second port music clock");
		complete_run();
	end
endmodule // tb_scr_config_regs
